/* design/iocch_cfg.svh */
// Contract
// - The I/O configuration register is 16 bits wide when the interface mode selects that length.
// - The power-down switch enable bit lets the switch pin sink current; it resets to zero.
// - The output pair enable bit enables both general outputs together; it resets to zero.
// - The hold input enable bit makes the hold pin a conversion hold input; it resets to one.
// - In normal hold mode the modulator and filter stay in reset while the hold pin is low.
// - The alternate hold behaviour replaces normal hold whenever the alternate hold bit is set and more than one channel is enabled; code needs hold_enable too.
// - Alternate hold is effective only while more than one channel is enabled.
// - In alternate hold a low hold pin does not reset the converter; a running conversion goes on.
// - In alternate hold a low hold pin at the channel switch point stops the next conversion.
// - In alternate hold the host raising the hold pin starts the pending conversion.
`ifndef IOCCH_CFG_SVH
`define IOCCH_CFG_SVH
`define IOCCH_ADDR_IOCFG    8'h00
`define IOCCH_ADDR_IFMODE   8'h04
`define IOCCH_ADDR_CHEN     8'h08
`define IOCCH_ADDR_STATUS   8'h0c
`define IOCCH_ADDR_ID       8'h10
`define IOCCH_BIT_RSVD15    15
`define IOCCH_BIT_POWER_DOWN_SWITCH_ENABLE      14
`define IOCCH_BIT_OPAIR     13
`define IOCCH_BIT_HOLDEN    11
`define IOCCH_BIT_GENERAL_OUTPUT_THREE      7
`define IOCCH_BIT_GENERAL_OUTPUT_TWO      6
`define IOCCH_BIT_ALTHOLD   0
`define IOCCH_BIT_LEN16     1
`define IOCCH_IOCFG_RESET   16'h0800
`define IOCCH_IOCFG_WMASK   16'h68c0
`define IOCCH_IFMODE_RESET  16'h0002
`define IOCCH_IFMODE_WMASK  16'h0003
`define IOCCH_CHEN_RESET    16'h0001
`define IOCCH_CONV_NS       4000
`define IOCCH_CLK_NS        4
`define IOCCH_CONV_CYCLES   (`IOCCH_CONV_NS / `IOCCH_CLK_NS)
`endif

/* design/iocch_pkg.sv */
package iocch_pkg;
  typedef enum logic [1:0] {
    IOCCH_IDLE = 2'b00,
    IOCCH_CONV = 2'b01,
    IOCCH_WAIT = 2'b10
  } iocch_state_t;

  typedef struct packed {
    logic power_down_switch_enable;
    logic output_pair_enable;
    logic hold_enable;
    logic general_output_two;
    logic general_output_three;
  } iocch_ctrl_t;

  typedef struct packed {
    logic conv_reset;
    logic conv_busy;
    logic conv_done;
    logic [3:0] channel;
  } iocch_conv_t;
endpackage

/* design/iocch_sequencer.sv */
`timescale 1ns/1ps
`include "iocch_cfg.svh"
module iocch_sequencer #(
  parameter int CONV_CYCLES = `IOCCH_CONV_CYCLES,
  parameter int NCH         = 16
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  hold_enable,
  input  wire logic                  alternate_hold_mode,
  input  wire logic [NCH-1:0]        chan_enable,
  input  wire logic                  hold_n,
  output iocch_pkg::iocch_conv_t     conv
);
  function automatic logic [4:0] ones(input logic [NCH-1:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < NCH; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic [3:0] next_chan(input logic [3:0] c, input logic [NCH-1:0] v);
    logic [3:0] r;
    logic       f;
    r = c;
    f = 1'b0;
    for (int k = 1; k <= NCH; k++) begin
      if (!f && v[(int'(c) + k) % NCH]) begin
        r = 4'((int'(c) + k) % NCH);
        f = 1'b1;
      end
    end
    return r;
  endfunction

  iocch_pkg::iocch_state_t state;
  iocch_pkg::iocch_state_t next_state;
  logic [31:0]             cnt;
  logic [3:0]              chan;
  logic                    done;

  wire multi     = ones(chan_enable) > 5'h01;
  wire alt_mode  = hold_enable && alternate_hold_mode && multi;
  wire norm_rst  = hold_enable && !alt_mode && !hold_n;
  wire any_en    = |chan_enable;
  wire conv_end  = (state == iocch_pkg::IOCCH_CONV) && (cnt == 32'(CONV_CYCLES - 1));
  // Gate only at the switch point so a running conversion is never cut short
  wire gate_stop = alt_mode && !hold_n;
  // Count only inside a running conversion so the first one after idle is full length
  wire cnt_run   = (state == iocch_pkg::IOCCH_CONV) && !conv_end
                && (next_state == iocch_pkg::IOCCH_CONV);

  always_comb begin
    next_state = state;
    case (state)
      iocch_pkg::IOCCH_IDLE: begin
        if (any_en) begin
          next_state = iocch_pkg::IOCCH_CONV;
        end
      end
      iocch_pkg::IOCCH_CONV: begin
        if (conv_end) begin
          next_state = gate_stop ? iocch_pkg::IOCCH_WAIT : iocch_pkg::IOCCH_CONV;
        end
      end
      iocch_pkg::IOCCH_WAIT: begin
        if (!gate_stop) begin
          next_state = iocch_pkg::IOCCH_CONV;
        end
      end
      default: next_state = iocch_pkg::IOCCH_IDLE;
    endcase
    if (!any_en) begin
      next_state = iocch_pkg::IOCCH_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || norm_rst) begin
      state <= iocch_pkg::IOCCH_IDLE;
      cnt   <= 32'h0000_0000;
      chan  <= 4'h0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      done  <= conv_end;
      cnt   <= cnt_run ? cnt + 32'h1 : 32'h0;
      if (conv_end) begin
        chan <= next_chan(chan, chan_enable);
      end
    end
  end

  assign conv = {norm_rst || state != iocch_pkg::IOCCH_CONV, state == iocch_pkg::IOCCH_CONV,
                 done, chan};

  ////////////////////////////////////////////////////////////////////////////
  a_hold_resets: assert property (@(posedge aclk) disable iff (!aresetn)
    (hold_enable && !alt_mode && !hold_n) |=> state == iocch_pkg::IOCCH_IDLE)
    else $error("hold low did not reset converter");
  a_alt_continue: assert property (@(posedge aclk) disable iff (!aresetn)
    (alt_mode && !hold_n && state == iocch_pkg::IOCCH_CONV && !conv_end && $stable(chan_enable))
    |=> state == iocch_pkg::IOCCH_CONV)
    else $error("alternate hold cut a running conversion");
  a_alt_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_end && gate_stop && any_en) |=> state == iocch_pkg::IOCCH_WAIT)
    else $error("conversion started while hold low");
  a_alt_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == iocch_pkg::IOCCH_WAIT && hold_n && any_en) |=> conv.conv_busy)
    else $error("pending conversion not begun");
  a_single_chan: assert property (@(posedge aclk) disable iff (!aresetn)
    (ones(chan_enable) <= 5'h01 && hold_enable && !hold_n)
    |=> state == iocch_pkg::IOCCH_IDLE)
    else $error("alternate hold active with one channel");
  a_ignore_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!hold_enable && any_en && state != iocch_pkg::IOCCH_IDLE) |=> conv.conv_busy)
    else $error("hold pin used while disabled");
  c_alt_wait: cover property (@(posedge aclk) state == iocch_pkg::IOCCH_WAIT ##[1:50] conv.conv_busy);
  c_norm_hold: cover property (@(posedge aclk) norm_rst ##1 !norm_rst);
  c_done: cover property (@(posedge aclk) conv.conv_done);
endmodule

/* design/iocch_top.sv */
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "iocch_cfg.svh"
module iocch_top #(
  parameter int          CONV_CYCLES = `IOCCH_CONV_CYCLES,
  parameter logic [15:0] DEVICE_ID   = 16'h5a5a  // Arbitrary identification value
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output wire logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output wire logic                  s_axi_wready,
  output wire logic [1:0]            s_axi_bresp,
  output wire logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output wire logic                  s_axi_arready,
  output wire logic [31:0]           s_axi_rdata,
  output wire logic [1:0]            s_axi_rresp,
  output wire logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  hold_n,
  output wire logic                  switch_sink,
  output wire logic                  general_output_two,
  output wire logic                  general_output_two_oe,
  output wire logic                  general_output_three,
  output wire logic                  general_output_three_oe,
  output iocch_pkg::iocch_conv_t     conv
);
  logic [15:0] io_pin_config;
  logic [15:0] if_mode;
  logic [15:0] chan_enable;
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        b_valid;
  logic [1:0]  b_resp;
  logic        r_valid;
  logic [31:0] r_data;
  logic [1:0]  r_resp;
  logic        sw;
  logic        g2;
  logic        g3;
  logic        oe;
  iocch_pkg::iocch_ctrl_t ctrl;

  function automatic logic known(input logic [7:0] a);
    return a == `IOCCH_ADDR_IOCFG || a == `IOCCH_ADDR_IFMODE || a == `IOCCH_ADDR_CHEN
        || a == `IOCCH_ADDR_STATUS || a == `IOCCH_ADDR_ID;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write path: address and data are latched independently, in any order
  assign s_axi_awready = !aw_held && !b_valid;
  assign s_axi_wready  = !w_held && !b_valid;
  wire aw_fire  = s_axi_awvalid && s_axi_awready;
  wire w_fire   = s_axi_wvalid && s_axi_wready;
  wire wr_go    = (aw_held || aw_fire) && (w_held || w_fire);
  wire [7:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
  wire wa_io    = wa == `IOCCH_ADDR_IOCFG;
  wire wa_mode  = wa == `IOCCH_ADDR_IFMODE;
  wire wa_chen  = wa == `IOCCH_ADDR_CHEN;
  wire wa_ok    = known(wa);

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Reserved bits are never stored, so bit 15 always reads zero
  wire [15:0] next_io = merge(io_pin_config, wd, ws) & `IOCCH_IOCFG_WMASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      b_valid <= 1'b0;
      b_resp  <= 2'h0;
    end else begin
      if (aw_fire && !wr_go) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire && !wr_go) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        b_valid <= 1'b1;
        b_resp  <= wa_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        b_valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_pin_config <= `IOCCH_IOCFG_RESET;
      if_mode       <= `IOCCH_IFMODE_RESET;
      chan_enable   <= `IOCCH_CHEN_RESET;
    end else if (wr_go) begin
      if (wa_io) begin
        io_pin_config <= next_io;
      end
      if (wa_mode) begin
        if_mode <= merge(if_mode, wd, ws) & `IOCCH_IFMODE_WMASK;
      end
      if (wa_chen) begin
        chan_enable <= merge(chan_enable, wd, ws);
      end
    end
  end

  assign s_axi_bvalid = b_valid;
  assign s_axi_bresp  = b_resp;

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  assign s_axi_arready = !r_valid;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire [7:0] ra = s_axi_araddr;
  // In 8-bit length mode only the low byte of the I/O register is visible
  wire [15:0] io_view = if_mode[`IOCCH_BIT_LEN16] ? io_pin_config
                                                  : {8'h00, io_pin_config[7:0]};
  wire [15:0] status  = {9'h000, conv.conv_busy, conv.conv_reset, hold_n, conv.channel};
  wire [15:0] rsel    = (ra == `IOCCH_ADDR_IOCFG)  ? io_view :
                        (ra == `IOCCH_ADDR_IFMODE) ? if_mode :
                        (ra == `IOCCH_ADDR_CHEN)   ? chan_enable :
                        (ra == `IOCCH_ADDR_STATUS) ? status :
                        (ra == `IOCCH_ADDR_ID)     ? DEVICE_ID : 16'h0000;
  wire ra_ok = known(ra);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_valid <= 1'b0;
      r_data  <= 32'h0000_0000;
      r_resp  <= 2'h0;
    end else if (ar_fire) begin
      r_valid <= 1'b1;
      r_data  <= {16'h0000, rsel};
      r_resp  <= ra_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      r_valid <= 1'b0;
    end
  end

  assign s_axi_rvalid = r_valid;
  assign s_axi_rdata  = r_data;
  assign s_axi_rresp  = r_resp;

  ////////////////////////////////////////////////////////////////////////////
  // Pin controls
  assign ctrl = {io_pin_config[`IOCCH_BIT_POWER_DOWN_SWITCH_ENABLE], io_pin_config[`IOCCH_BIT_OPAIR],
                 io_pin_config[`IOCCH_BIT_HOLDEN], io_pin_config[`IOCCH_BIT_GENERAL_OUTPUT_TWO],
                 io_pin_config[`IOCCH_BIT_GENERAL_OUTPUT_THREE]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw <= 1'b0;
      oe <= 1'b0;
      g2 <= 1'b0;
      g3 <= 1'b0;
    end else begin
      sw <= ctrl.power_down_switch_enable;
      oe <= ctrl.output_pair_enable;
      g2 <= ctrl.output_pair_enable & ctrl.general_output_two;
      g3 <= ctrl.output_pair_enable & ctrl.general_output_three;
    end
  end

  assign switch_sink             = sw;
  assign general_output_two      = g2;
  assign general_output_three    = g3;
  assign general_output_two_oe   = oe;
  assign general_output_three_oe = oe;

  iocch_sequencer #(
    .CONV_CYCLES (CONV_CYCLES),
    .NCH         (16)
  ) u_seq (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .hold_enable         (ctrl.hold_enable),
    .alternate_hold_mode (if_mode[`IOCCH_BIT_ALTHOLD]),
    .chan_enable         (chan_enable),
    .hold_n              (hold_n),
    .conv                (conv)
  );

  ////////////////////////////////////////////////////////////////////////////
  a_io_reset_val: assert property (@(posedge aclk)
    $rose(aresetn) |-> io_pin_config == `IOCCH_IOCFG_RESET)
    else $error("I/O configuration reset value wrong");
  a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    io_pin_config[`IOCCH_BIT_RSVD15] == 1'b0)
    else $error("reserved bit set");
  a_pair_oe: assert property (@(posedge aclk) disable iff (!aresetn)
    general_output_two_oe == general_output_three_oe
    && ($past(ctrl.output_pair_enable) == general_output_two_oe))
    else $error("output pair enables disagree");
  a_switch_sink: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 switch_sink == $past(io_pin_config[`IOCCH_BIT_POWER_DOWN_SWITCH_ENABLE]))
    else $error("switch sink not following enable");
  a_len_view: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_fire && ra == `IOCCH_ADDR_IOCFG && !if_mode[`IOCCH_BIT_LEN16])
    |=> s_axi_rdata[15:8] == 8'h00)
    else $error("short length read exposed upper byte");
  c_write_io: cover property (@(posedge aclk) wr_go && wa_io);
  c_alt_on: cover property (@(posedge aclk) if_mode[`IOCCH_BIT_ALTHOLD] && ctrl.hold_enable);
endmodule

/* tb/io_config_conversion_hold_test.sv */
`timescale 1ns/1ps
`include "iocch_cfg.svh"
module io_config_conversion_hold_test;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go;
  logic [7:0] awaddr, araddr, lag;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, hold_n;
  logic sw, g2, g2oe, g3, g3oe;
  iocch_pkg::iocch_conv_t conv;
  int n_mismatch = 0;
  int n_checks   = 0;
  logic [31:0] d;
  logic [1:0] r;
  wire logic [4:0] outs = {sw, g2, g2oe, g3, g3oe};
  iocch_top #(.CONV_CYCLES(8), .DEVICE_ID(16'h1357)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hold_n(hold_n),
    .switch_sink(sw), .general_output_two(g2), .general_output_two_oe(g2oe),
    .general_output_three(g3), .general_output_three_oe(g3oe), .conv(conv)
  );
  iocch_host_model u_host (.aclk(aclk), .go(go), .lag(lag), .hold_n(hold_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  // Handshake values are sampled before the edge's own updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    rd(a);
    chk(d === e && r === 2'b00, m);
  endtask
  task automatic out_chk(input logic [4:0] e, input string m);
    repeat (2) @(posedge aclk);
    #1;
    chk(outs === e, m);
  endtask
  // Bounded wait for one bit of the conversion status
  task automatic wait_chk(input int sel, input logic v, input int lim, input string m);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge aclk);
      #1;
      ok = (conv[sel] === v);
    end
    chk(ok, m);
  endtask
  task automatic hold(input logic up, input logic [7:0] l);
    @(posedge aclk);
    go  <= up;
    lag <= l;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = '0;
    go  = 1'b1;
    lag = 8'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`IOCCH_ADDR_IOCFG, 32'h0000_0800, "iocfg reset");
    rd_chk(`IOCCH_ADDR_IFMODE, 32'h0000_0002, "16-bit length at reset");
    rd_chk(`IOCCH_ADDR_ID, 32'h0000_1357, "id value");
    chk(outs === 5'h00, "outputs at reset");
    wr(`IOCCH_ADDR_IOCFG, 32'h0000_7fff);
    rd_chk(`IOCCH_ADDR_IOCFG, 32'h0000_68c0, "reserved bits read zero");
    out_chk(5'h1f, "switch and pair on");
    wr(`IOCCH_ADDR_IOCFG, 32'h0000_2040);
    out_chk(5'h0d, "pair enabled together");
    wr(`IOCCH_ADDR_IOCFG, 32'h0000_0880);
    out_chk(5'h00, "pair disabled");
    wr(`IOCCH_ADDR_IFMODE, 32'h0000_0001);
    rd_chk(`IOCCH_ADDR_IOCFG, 32'h0000_0080, "8-bit length shows low byte");
    rd(8'h20);
    chk(r === 2'b10, "unmapped read not refused");
    wr(8'h20, 32'h0);
    chk(r === 2'b10, "unmapped write not refused");
    // Normal hold with two channels and alternate mode off
    wr(`IOCCH_ADDR_IFMODE, 32'h0000_0002);
    wr(`IOCCH_ADDR_CHEN, 32'h0000_0003);
    hold(1'b0, 8'h00);
    wait_chk(6, 1'b1, 3, "hold low resets converter");
    @(posedge aclk);
    #1;
    chk(conv.conv_busy === 1'b0, "busy during hold");
    hold(1'b1, 8'h00);
    wait_chk(5, 1'b1, 6, "release starts conversion");
    // Alternate mode: one channel behaves as normal hold, two channels gate at the switch point
    wr(`IOCCH_ADDR_IFMODE, 32'h0000_0003);
    wr(`IOCCH_ADDR_CHEN, 32'h0000_0001);
    hold(1'b0, 8'h00);
    wait_chk(6, 1'b1, 3, "single channel ignores alternate mode");
    hold(1'b1, 8'h00);
    wr(`IOCCH_ADDR_CHEN, 32'h0000_0003);
    wait_chk(4, 1'b1, 30, "conversion end seen");
    chk(conv.channel === 4'h1, "channel advanced");
    wait_chk(5, 1'b1, 4, "next conversion running");
    hold(1'b0, 8'h00);
    repeat (2) @(posedge aclk);
    #1;
    chk(conv[6:5] === 2'b01, "running conversion goes on");
    wait_chk(4, 1'b1, 12, "conversion finishes under hold");
    chk(conv.channel === 4'h0, "channel wrapped");
    repeat (3) @(posedge aclk);
    #1;
    chk(conv[6:5] === 2'b10, "next conversion held back");
    rd_chk(`IOCCH_ADDR_STATUS, 32'h0000_0020, "status while waiting");
    hold(1'b1, 8'h03);
    repeat (2) @(posedge aclk);
    #1;
    chk(conv.conv_busy === 1'b0, "waits for late release");
    wait_chk(5, 1'b1, 8, "release begins pending conversion");
    // Hold input disabled: the pin level must not matter
    wr(`IOCCH_ADDR_IFMODE, 32'h0000_0002);
    wr(`IOCCH_ADDR_IOCFG, 32'h0000_0000);
    hold(1'b0, 8'h00);
    repeat (3) @(posedge aclk);
    #1;
    chk(conv.conv_reset === 1'b0, "disabled hold ignored");
    wait_chk(4, 1'b1, 20, "conversions continue ungated");
    hold(1'b1, 8'h00);
    finish_test();
  end
endmodule

/* tb/iocch_host_model.sv */
`timescale 1ns/1ps
module iocch_host_model (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [7:0] lag,
  output wire logic       hold_n
);
  logic [7:0] wait_cnt = 8'h00;
  logic       level    = 1'b1;
  assign hold_n = level;
  // Holds at once but may release late, so gating is seen to wait
  always @(posedge aclk) begin
    if (!go) begin
      wait_cnt <= 8'h00;
      level    <= 1'b0;
    end else if (wait_cnt < lag) begin
      wait_cnt <= wait_cnt + 8'h01;
    end else begin
      level <= 1'b1;
    end
  end
endmodule
